// *** wdt_top.sv ***
// windowed watchdog: registers, settings transfer, slow-tick counter
module wdt_top #(
   parameter int TICK_DIV = wdt_pkg::TICK_DIV
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // register port
   input  wire logic [1:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // fuses and protection
   input  wire logic [3:0] default_timeout_fuses_i,
   input  wire logic [3:0] default_window_fuses_i,
   input  wire logic       fuse_enable_i,
   input  wire logic       fuse_window_en_i,
   input  wire logic       lock_fuse_i,
   input  wire logic       ccp_permit_i,
   // restart and reset request
   input  wire logic       restart_command_i,
   output logic            sys_reset_req_o
);
   typedef enum logic [2:0] {
      WDT_OFF    = 3'h1,
      WDT_CLOSED = 3'h2,
      WDT_OPEN   = 3'h4
   } wdt_state_e;

   logic       tick;
   logic       boot_ff;
   logic [3:0] tsel_ff;
   logic       en_ff;
   logic       ctl_chg_ff;
   logic [3:0] wsel_ff;
   logic       wen_ff;
   logic       win_chg_ff;
   logic       busy_ff;
   logic [1:0] busy_cnt_ff;
   logic [3:0] act_tsel_ff;
   logic [3:0] act_wsel_ff;
   logic       act_en_ff;
   logic       act_wen_ff;
   logic       rst_pend_ff;
   logic       rst_seen_ff;
   logic [wdt_pkg::CNT_W-1:0] cnt_ff;
   wdt_state_e state_ff;
   wdt_state_e nxt_state;
   logic [7:0] rdata_ff;
   logic       req_ff;
   logic [wdt_pkg::CNT_W-1:0] to_cyc;
   logic [wdt_pkg::CNT_W-1:0] win_cyc;
   logic       to_ok;
   logic       win_ok;
   logic       wr_ctl;
   logic       wr_win;

   initial begin
      if (TICK_DIV < 2) $error("tick divider too small");
   end

   wdt_tick_div #(.DIV(TICK_DIV)) u_div (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .tick_o    (tick)
   );

   wdt_period u_to (
      .code_i   (act_tsel_ff),
      .cycles_o (to_cyc),
      .valid_o  (to_ok)
   );

   wdt_period u_win (
      .code_i   (act_wsel_ff),
      .cycles_o (win_cyc),
      .valid_o  (win_ok)
   );

   // protection qualifies both writes, lock only the control write; bit 0 of the written value must be one
   assign wr_ctl = wr_i && addr_i == wdt_pkg::ADDR_CTRL && ccp_permit_i
                   && wdata_i[wdt_pkg::CHG_BIT] && !lock_fuse_i;
   assign wr_win = wr_i && addr_i == wdt_pkg::ADDR_WINCTL && ccp_permit_i
                   && wdata_i[wdt_pkg::CHG_BIT];

   // fuses caught one cycle after reset release, not under reset
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         boot_ff <= 1'b1;
      end else begin
         boot_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         tsel_ff    <= '0;
         en_ff      <= 1'b0;
         ctl_chg_ff <= 1'b0;
      end else if (boot_ff) begin
         tsel_ff    <= default_timeout_fuses_i;
         en_ff      <= fuse_enable_i;
         ctl_chg_ff <= 1'b0;
      end else if (wr_ctl) begin
         tsel_ff    <= wdata_i[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB];
         en_ff      <= wdata_i[wdt_pkg::EN_BIT];
         ctl_chg_ff <= wdata_i[wdt_pkg::CHG_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wsel_ff    <= '0;
         wen_ff     <= 1'b0;
         win_chg_ff <= 1'b0;
      end else if (boot_ff) begin
         wsel_ff    <= default_window_fuses_i;
         wen_ff     <= fuse_window_en_i;
         win_chg_ff <= 1'b0;
      end else if (wr_win) begin
         if (!lock_fuse_i) begin
            wsel_ff <= wdata_i[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB];
         end
         wen_ff     <= wdata_i[wdt_pkg::EN_BIT];
         win_chg_ff <= wdata_i[wdt_pkg::CHG_BIT];
      end
   end

   // settings cross on slow ticks; this holds only while enabled
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         busy_ff     <= 1'b0;
         busy_cnt_ff <= '0;
      end else if (boot_ff || wr_ctl || wr_win) begin
         busy_ff     <= 1'b1;
         busy_cnt_ff <= '0;
      end else if (busy_ff && tick && (en_ff || act_en_ff)) begin
         if (busy_cnt_ff == 2'(wdt_pkg::SYNC_TICKS - 1)) begin
            busy_ff <= 1'b0;
         end
         busy_cnt_ff <= busy_cnt_ff + 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         act_tsel_ff <= '0;
         act_wsel_ff <= '0;
         act_en_ff   <= 1'b0;
         act_wen_ff  <= 1'b0;
      end else if (busy_ff && tick && (en_ff || act_en_ff)
                   && busy_cnt_ff == 2'(wdt_pkg::SYNC_TICKS - 1)) begin
         act_tsel_ff <= tsel_ff;
         act_wsel_ff <= wsel_ff;
         act_en_ff   <= en_ff;
         act_wen_ff  <= wen_ff;
      end
   end

   // restart pulse held until next slow tick; set wins over the consume
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rst_pend_ff <= 1'b0;
      end else if (restart_command_i) begin
         rst_pend_ff <= 1'b1;
      end else if (tick) begin
         rst_pend_ff <= 1'b0;
      end
   end
   assign rst_seen_ff = rst_pend_ff && tick;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         WDT_OFF: begin
            if (act_en_ff) begin
               nxt_state = act_wen_ff ? WDT_CLOSED : WDT_OPEN;
            end
         end
         WDT_CLOSED: begin
            if (!act_en_ff) begin
               nxt_state = WDT_OFF;
            end else if (!act_wen_ff) begin
               nxt_state = WDT_OPEN;
            end else if (tick && !rst_seen_ff && win_ok && cnt_ff >= win_cyc - 1'b1) begin
               nxt_state = WDT_OPEN;
            end
         end
         WDT_OPEN: begin
            if (!act_en_ff) begin
               nxt_state = WDT_OFF;
            end else if (rst_seen_ff && act_wen_ff) begin
               nxt_state = WDT_CLOSED;
            end
         end
         default: nxt_state = WDT_OFF;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_ff <= WDT_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i || state_ff != nxt_state || state_ff == WDT_OFF) begin
         cnt_ff <= '0;
      end else if (tick) begin
         if (rst_seen_ff) begin
            cnt_ff <= '0;
         end else if (cnt_ff != '1) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

   // one-cycle reset request on early restart or expiry
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         req_ff <= 1'b0;
      end else begin
         req_ff <= tick && ((state_ff == WDT_CLOSED && act_wen_ff && rst_seen_ff)
                  || (state_ff == WDT_OPEN && !rst_seen_ff && to_ok
                      && cnt_ff == to_cyc - 1'b1));
      end
   end
   assign sys_reset_req_o = req_ff;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rdata_ff <= '0;
      end else if (rd_i) begin
         case (addr_i)
            wdt_pkg::ADDR_CTRL:   rdata_ff <= {2'h0, tsel_ff, en_ff, ctl_chg_ff};
            wdt_pkg::ADDR_WINCTL: rdata_ff <= {2'h0, wsel_ff, wen_ff, win_chg_ff};
            wdt_pkg::ADDR_STATUS: rdata_ff <= {7'h00, busy_ff};
            default:              rdata_ff <= '0;
         endcase
      end else begin
         rdata_ff <= '0;
      end
   end
   assign rdata_o = rdata_ff;

   // either window mode: a restart in the open state never asks for reset
   restart_open_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (tick && state_ff == WDT_OPEN && rst_seen_ff) |=> !req_ff)
      else $error("restart in open period caused reset");
   early_restart_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (tick && state_ff == WDT_CLOSED && act_wen_ff && act_en_ff && rst_seen_ff) |=> req_ff)
      else $error("early restart did not reset");
   reserved_code_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_ff == WDT_OPEN && !to_ok) |=> !req_ff)
      else $error("reserved timeout code expired");
   locked_ctl_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || boot_ff)
      (lock_fuse_i && wr_i) |=> $stable(tsel_ff) && $stable(en_ff))
      else $error("locked control changed");
   no_permit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || boot_ff)
      (wr_i && !ccp_permit_i) |=> $stable(wsel_ff) && $stable(wen_ff))
      else $error("unprotected write took effect");
   cen_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || boot_ff)
      (wr_i && !wdata_i[wdt_pkg::CHG_BIT]) |=> $stable(tsel_ff) && $stable(wsel_ff))
      else $error("write without change enable");
   busy_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_ctl || wr_win) |=> busy_ff)
      else $error("busy not set after write");
   busy_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (busy_ff && !en_ff && !act_en_ff && !wr_ctl && !wr_win) |=> busy_ff)
      else $error("transfer while disabled");
   off_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_ff == WDT_OFF) |=> !req_ff)
      else $error("reset request while disabled");
   rsv_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      rd_i |=> rdata_o[7:6] == 2'h0)
      else $error("reserved bits nonzero");
endmodule

// *** wdt_pkg.sv ***
// package: register map, field layout, timing constants for the windowed watchdog
// Function
// - timeout code selects 8 to 8192 slow cycles
// - reserved timeout codes never expire
// - enable bit runs watchdog, clearing stops it
// - enable changes only with control change-enable set
// - writes update only when written bit 0 set
// - writes accepted only when protection permits
// - closed window code selects 8 to 8192 cycles
// - reserved closed window codes never expire
// - window period ignored when window mode off
// - window period changes only with window change-enable
// - window bit 1 enables window mode
// - lock fuse freezes control and window period
// - power-on loads fuses, clears change-enables
// - busy flag set during slow-domain transfer
// - transfer happens only while watchdog enabled
// - reserved bits read zero
// - normal mode restart begins fresh period
// - restart in closed window resets system
// - counter runs on 1 kHz tick
package wdt_pkg;
   localparam logic [1:0] ADDR_CTRL   = 2'h0;
   localparam logic [1:0] ADDR_WINCTL = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   localparam int         CHG_BIT     = 0;
   localparam int         EN_BIT      = 1;
   localparam int         SEL_LSB     = 2;
   localparam int         SEL_MSB     = 5;
   localparam logic [3:0] SEL_MAX     = 4'hA;
   localparam int         CNT_W       = 14;
   localparam logic [CNT_W-1:0] CYC_BASE = 14'h0008;
   localparam int         CLK_HZ      = 200_000_000;
   localparam int         TICK_HZ     = 1_000;
   localparam int         TICK_DIV    = CLK_HZ / TICK_HZ;
   localparam int         SYNC_TICKS  = 2;
endpackage

// *** wdt_tick_div.sv ***
// divider producing the 1 kHz slow tick enable
module wdt_tick_div #(
   parameter int DIV = wdt_pkg::TICK_DIV
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // tick
   output logic      tick_o
);
   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt_ff;

   initial begin
      if (DIV < 2) $error("divider too small");
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i || cnt_ff == W'(DIV - 1)) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + W'(1);
      end
   end

   assign tick_o = (cnt_ff == W'(DIV - 1));
endmodule

// *** wdt_period.sv ***
// decode of a four-bit period code into slow-cycle count
module wdt_period (
   // code
   input  wire logic [3:0]                code_i,
   // result
   output logic      [wdt_pkg::CNT_W-1:0] cycles_o,
   output logic                           valid_o
);
   assign valid_o  = (code_i <= wdt_pkg::SEL_MAX);
   assign cycles_o = wdt_pkg::CYC_BASE << code_i;
endmodule

// *** test_windowed_watchdog_timer.sv ***
// register-level testbench for the windowed watchdog
module test_windowed_watchdog_timer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 4; // short tick divider keeps long periods affordable
   logic       clk_i = 1'b0;
   logic       reset_n_i = 1'b0;
   logic [1:0] addr_i = 2'h0;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic       lock_fuse_i = 1'b0;
   logic       ccp_permit_i = 1'b1;
   logic       restart_command_i = 1'b0;
   logic       sys_reset_req_o;
   int         num_errors = 0;
   int         tests_run = 0;
   int         n;
   logic [7:0] d;

   always #2.5 clk_i = ~clk_i;

   wdt_top #(.TICK_DIV(T)) uut (
      .clk_i                   (clk_i),
      .reset_n_i               (reset_n_i),
      .addr_i                  (addr_i),
      .wdata_i                 (wdata_i),
      .wr_i                    (wr_i),
      .rd_i                    (rd_i),
      .rdata_o                 (rdata_o),
      .default_timeout_fuses_i (4'h1),
      .default_window_fuses_i  (4'h2),
      .fuse_enable_i           (1'b0),
      .fuse_window_en_i        (1'b0),
      .lock_fuse_i             (lock_fuse_i),
      .ccp_permit_i            (ccp_permit_i),
      .restart_command_i       (restart_command_i),
      .sys_reset_req_o         (sys_reset_req_o)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      v = rdata_o;
   endtask

   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] v;
      rd(a, v);
      chk({8'h00, v}, {8'h00, exp}, msg);
   endtask

   // busy must clear within a few ticks once the watchdog is enabled
   task automatic wait_idle();
      logic [7:0] v;
      int k;
      k = 0;
      do begin
         rd(2'h2, v);
         k++;
      end while (v !== 8'h00 && k < 12 * T);
      chk({8'h00, v}, 16'h0000, "sync busy did not clear");
   endtask

   // clocks until the next reset request, limited to lim ticks
   task automatic wait_pulse(input int lim, output int c);
      c = 0;
      do begin
         @(posedge clk_i);
         #1;
         c++;
      end while (sys_reset_req_o !== 1'b1 && c < lim * T);
   endtask

   task automatic restart();
      @(posedge clk_i);
      restart_command_i <= 1'b1;
      @(posedge clk_i);
      restart_command_i <= 1'b0;
   endtask

   task automatic no_pulse(input int ticks, input string msg);
      int p;
      p = 0;
      repeat (ticks * T) begin
         @(posedge clk_i);
         #1;
         if (sys_reset_req_o !== 1'b0) p++;
      end
      chk(16'(p), 16'h0000, msg);
   endtask

   task automatic finish_test();
      $display("checks made %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #(20_000 * 5);
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rd_chk(2'h0, 8'h04, "control after power-on");
      rd_chk(2'h1, 8'h08, "window after power-on");
      rd_chk(2'h2, 8'h01, "busy held while disabled");
      rd_chk(2'h3, 8'h00, "unmapped read");
      $display("power-on test done");
      wr(2'h0, 8'h0A);
      rd_chk(2'h0, 8'h04, "write without change enable");
      ccp_permit_i <= 1'b0;
      wr(2'h0, 8'h0B);
      wr(2'h1, 8'h0B);
      ccp_permit_i <= 1'b1;
      rd_chk(2'h0, 8'h04, "control write without permit");
      rd_chk(2'h1, 8'h08, "window write without permit");
      wr(2'h1, 8'h16);
      rd_chk(2'h1, 8'h08, "window write without change enable");
      $display("refused write test done");
      // the count runs on after a request, so a restart opens each measured period
      for (int c = 0; c < 4; c++) begin
         wr(2'h0, 8'((c << 2) | 3));
         rd_chk(2'h0, 8'((c << 2) | 3), "control write");
         wait_idle();
         restart();
         wait_pulse(80, n);
         chk(16'(n >= (8 << c) * T && n <= ((8 << c) + 1) * T), 16'h0001,
             "timeout interval");
      end
      restart();
      wait_pulse(80, n);
      chk(16'(n >= 64 * T && n <= 65 * T), 16'h0001, "pulse before restart run");
      repeat (8) begin
         no_pulse(6, "restart run");
         restart();
      end
      no_pulse(50, "restart run");
      $display("normal mode test done");
      wr(2'h0, 8'h2F);
      wait_idle();
      no_pulse(100, "reserved timeout code");
      restart();
      wr(2'h0, 8'h0B);
      wr(2'h1, 8'h03);
      rd_chk(2'h1, 8'h03, "window enable");
      wait_idle();
      wait_pulse(60, n);
      restart(); // open-period restart starts the closed window
      repeat (2 * T) @(posedge clk_i);
      restart();
      wait_pulse(3, n);
      chk({15'h0, sys_reset_req_o}, 16'h0001, "restart in closed window");
      wait_pulse(60, n);
      chk(16'(n >= 40 * T && n <= 41 * T), 16'h0001, "closed then open period");
      repeat (12 * T) @(posedge clk_i);
      restart();
      no_pulse(30, "restart in open window");
      $display("window mode test done");
      lock_fuse_i <= 1'b1;
      wr(2'h0, 8'h01);
      rd_chk(2'h0, 8'h0B, "locked control");
      wr(2'h1, 8'h15);
      rd_chk(2'h1, 8'h01, "locked window period");
      wait_idle();
      restart();
      wait_pulse(40, n);
      chk(16'(n >= 32 * T && n <= 33 * T), 16'h0001, "window off uses open period");
      lock_fuse_i <= 1'b0;
      wr(2'h0, 8'hC1);
      rd_chk(2'h0, 8'h01, "disable with reserved bits");
      wait_idle();
      no_pulse(80, "disabled watchdog");
      $display("lock and disable test done");
      finish_test();
   end
endmodule
